/* rtl/tms_scan_sequencer.sv */
// scan sequencer for the capacitive touch key matrix
`timescale 1ns/100ps
`default_nettype none
`include "tms_consts.svh"
module tms_scan_sequencer (
  // clock and reset
  input  wire logic                                     clk_sys,
  input  wire logic                                     resetn,
  // variant strap: high selects the 16-key part
  input  wire logic                                     smallVariant,
  // per-key setup, flattened key-major
  input  wire logic [`TMS_NUM_KEYS*`TMS_LIMIT_W-1:0]    normalDetectIntegratorLimit,
  input  wire logic [`TMS_NUM_KEYS*`TMS_BURST_W-1:0]    pulseBurstCount,
  // sense comparator
  input  wire logic                                     senseAbove,
  // matrix drive
  output logic [`TMS_NUM_DRIVE-1:0]                     driveLine,
  output logic [`TMS_NUM_SENSE-1:0]                     senseSelect,
  // results
  output logic                                          resultValid,
  output logic [`TMS_KEY_W-1:0]                         resultKey,
  output logic [`TMS_SIG_W-1:0]                         resultSignal,
  output logic [`TMS_NUM_KEYS-1:0]                      keyEnabled,
  output logic [`TMS_KEY_W-1:0]                         enabledCount,
  output logic                                          overLimit,
  output logic                                          scanDone
);
  tms_acq_if acqBus ();
  tms_pkg::tms_state_t       state_r;        // sequencer phase
  logic [`TMS_KEY_W-1:0]     key_r;          // key being visited
  logic [`TMS_NUM_KEYS-1:0]  enPrev_r;       // mask seen last cycle
  logic                      start_r;        // burst start strobe
  logic [`TMS_BURST_W-1:0]   pulses_r;       // latched burst length
  logic                      smallLatched_r; // strap caught after reset
  logic                      strapValid_r;   // strap has been caught
  logic                      restart_r;      // mask changed, restart still owed
  logic [`TMS_NUM_DRIVE-1:0] drive_r;
  logic [`TMS_NUM_SENSE-1:0] sense_r;
  logic                      valid_r;
  logic [`TMS_KEY_W-1:0]     rkey_r;
  logic [`TMS_SIG_W-1:0]     rsig_r;
  logic [`TMS_NUM_KEYS-1:0]  enOut_r;
  logic [`TMS_KEY_W-1:0]     count_r;
  logic                      over_r;
  logic                      done_r;
  // per-key enable derived from the integrator limit
  logic [`TMS_NUM_KEYS-1:0]  rawEnable;
  logic [`TMS_NUM_KEYS-1:0]  keyEnable;
  genvar g;
  generate
    for (g = 0; g < `TMS_NUM_KEYS; g++) begin : gEn
      assign rawEnable[g] = normalDetectIntegratorLimit[g*`TMS_LIMIT_W +: `TMS_LIMIT_W]
                            != '0;
    end
  endgenerate
  // small part: third sense line scanned only while at most 16 keys are enabled; host must disable defaults
  // itself to move keys there, so all 24 key slots count toward the limit
  wire [`TMS_NUM_KEYS-1:0] smallMask = {{(`TMS_NUM_KEYS-`TMS_MAX_SMALL){1'b0}},
                                        {`TMS_MAX_SMALL{1'b1}}};
  wire                     isSmall   = strapValid_r ? smallLatched_r : smallVariant;
  // count enabled keys before limiting
  logic [`TMS_KEY_W-1:0] rawCount;
  always_comb begin
    rawCount = '0;
    for (int i = 0; i < `TMS_NUM_KEYS; i++) begin
      rawCount = rawCount + `TMS_KEY_W'(rawEnable[i]);
    end
  end
  wire smallOver = isSmall && (rawCount > `TMS_KEY_W'(`TMS_MAX_SMALL));
  // over the limit: keep only the enabled keys of the first two lines
  assign keyEnable = !isSmall ? rawEnable :
                     smallOver ? (rawEnable & smallMask) :
                     rawEnable;
  // next enabled key search
  wire                  found;
  wire [`TMS_KEY_W-1:0] nextKey;
  wire                  atStart = (state_r == tms_pkg::ST_IDLE) || (state_r == tms_pkg::ST_DONE);
  wire [`TMS_KEY_W-1:0] fromKey = atStart ? `TMS_FIRST_KEY : key_r + `TMS_KEY_W'(1);
  tms_key_select uSel (
    .keyEnable (keyEnable),
    .fromKey   (fromKey),
    .found     (found),
    .nextKey   (nextKey)
  );
  wire maskChanged = (keyEnable != enPrev_r);
  // a change seen mid-burst is held until the converter is idle, else it is lost;
  // start_r covers the cycle before the converter reports busy
  wire restartOwed = maskChanged || restart_r;
  wire restartNow  = restartOwed && (state_r != tms_pkg::ST_IDLE) && !acqBus.busy
                     && !start_r;
  // drive and sense line of the key: key = sense*8 + drive
  wire [2:0] driveIdx = nextKey[2:0];
  wire [1:0] senseIdx = nextKey[4:3];
  wire [`TMS_BURST_W-1:0] nextPulses = pulseBurstCount[nextKey*`TMS_BURST_W +: `TMS_BURST_W];
  assign acqBus.start  = start_r;
  assign acqBus.pulses = pulses_r;
  tms_acquire uAcq (
    .clk_sys    (clk_sys),
    .resetn     (resetn),
    .senseAbove (senseAbove),
    .acq        (acqBus.acq)
  );
  // strap capture one clock after reset release
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      strapValid_r   <= 1'b0;
      smallLatched_r <= 1'b0;
    end else if (!strapValid_r) begin
      strapValid_r   <= 1'b1;
      smallLatched_r <= smallVariant;
    end
  end
  // sequencer: one key at a time, restart on mask change
  always_ff @(posedge clk_sys) begin
    start_r <= 1'b0;
    done_r  <= 1'b0;
    valid_r <= 1'b0;
    if (!resetn) begin
      state_r  <= tms_pkg::ST_IDLE;
      key_r    <= `TMS_FIRST_KEY;
      enPrev_r <= '0;
      restart_r <= 1'b0;
      pulses_r <= '0;
      drive_r  <= '0;
      sense_r  <= '0;
      rkey_r   <= '0;
      rsig_r   <= '0;
    end else begin
      enPrev_r <= keyEnable;
      // idle already restarts from the lowest key, so nothing is owed there
      restart_r <= restartOwed && !restartNow && (state_r != tms_pkg::ST_IDLE);
      if (restartNow) begin
        state_r <= tms_pkg::ST_IDLE;
      end else begin
        case (state_r)
          tms_pkg::ST_IDLE, tms_pkg::ST_DONE, tms_pkg::ST_FIND: begin
            if (found) begin
              key_r    <= nextKey;
              pulses_r <= nextPulses;
              start_r  <= 1'b1;
              drive_r  <= 8'h01 << driveIdx;
              sense_r  <= 3'h1 << senseIdx;
              state_r  <= tms_pkg::ST_BURST;
            end else begin
              state_r <= tms_pkg::ST_IDLE;
            end
          end
          // a result taken under the old mask is dropped: its key may now be off
          tms_pkg::ST_BURST: if (acqBus.done && !restartOwed) begin
            // disabled keys never reach here, so they never produce a result
            rsig_r  <= acqBus.value;
            rkey_r  <= key_r;
            valid_r <= 1'b1;
            state_r <= tms_pkg::ST_CONV;
          end
          tms_pkg::ST_CONV: begin
            // burst fully ended before searching the next key
            if (found) begin
              state_r <= tms_pkg::ST_FIND;
            end else begin
              // no enabled key above this one: the scan cycle is over
              done_r  <= 1'b1;
              state_r <= tms_pkg::ST_DONE;
            end
          end
          default: state_r <= tms_pkg::ST_IDLE;
        endcase
      end
    end
  end
  // pulse level is gated onto the selected drive line only while bursting
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      driveLine   <= '0;
      senseSelect <= '0;
      enOut_r     <= '0;
      count_r     <= '0;
      over_r      <= 1'b0;
    end else begin
      driveLine   <= acqBus.pulseHigh ? drive_r : '0;
      senseSelect <= sense_r;
      enOut_r     <= keyEnable;
      count_r     <= smallOver ? `TMS_KEY_W'(`TMS_MAX_SMALL) : rawCount;
      over_r      <= smallOver;
    end
  end
  assign resultValid  = valid_r;
  assign resultKey    = rkey_r;
  assign resultSignal = rsig_r;
  assign keyEnabled   = enOut_r;
  assign enabledCount = count_r;
  assign overLimit    = over_r;
  assign scanDone     = done_r;
endmodule
`default_nettype wire

/* rtl/tms_consts.svh */
// constants for the touch matrix scan sequencer
`ifndef TMS_CONSTS_SVH
`define TMS_CONSTS_SVH
`define TMS_NUM_DRIVE    8
`define TMS_NUM_SENSE    3
`define TMS_NUM_KEYS     24
`define TMS_KEY_W        5
`define TMS_MAX_SMALL    16
`define TMS_MAX_LARGE    24
`define TMS_LIMIT_W      8
`define TMS_BURST_W      8
`define TMS_SIG_W        12
`define TMS_FIRST_KEY    5'h00
`define TMS_PULSE_HALF   8'h02
`define TMS_CONV_CYCLES  8'h10
`endif

/* rtl/tms_pkg.sv */
// types of the touch matrix scan sequencer
package tms_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_FIND, ST_BURST, ST_CONV, ST_DONE} tms_state_t;
endpackage

/* rtl/tms_acq_if.sv */
// interface between sequencer and acquisition unit
`timescale 1ns/100ps
`default_nettype none
`include "tms_consts.svh"
interface tms_acq_if;
  logic                       start;      // one-cycle start of a burst
  logic [`TMS_BURST_W-1:0]    pulses;     // pulse count for the burst
  logic                       pulseHigh;  // drive pulse level
  logic                       busy;       // burst or conversion running
  logic                       done;       // one-cycle: value ready
  logic [`TMS_SIG_W-1:0]      value;      // digitised result
  modport seq (output start, pulses, input pulseHigh, busy, done, value);
  modport acq (input start, pulses, output pulseHigh, busy, done, value);
endinterface
`default_nettype wire

/* rtl/tms_key_select.sv */
// finds next enabled key at or after a start index
`timescale 1ns/100ps
`default_nettype none
`include "tms_consts.svh"
module tms_key_select (
  // enable mask and search start
  input  wire logic [`TMS_NUM_KEYS-1:0] keyEnable,
  input  wire logic [`TMS_KEY_W-1:0]    fromKey,
  // result
  output logic                          found,
  output logic [`TMS_KEY_W-1:0]         nextKey
);
  logic [`TMS_NUM_KEYS-1:0] hit;        // enabled and not below start
  // lowest set bit wins, so the ordering follows key number
  genvar g;
  generate
    for (g = 0; g < `TMS_NUM_KEYS; g++) begin : gHit
      assign hit[g] = keyEnable[g] && (`TMS_KEY_W'(g) >= fromKey);
    end
  endgenerate
  always_comb begin
    found   = 1'b0;
    nextKey = `TMS_FIRST_KEY;
    for (int i = `TMS_NUM_KEYS - 1; i >= 0; i--) begin
      if (hit[i]) begin
        found   = 1'b1;
        nextKey = i[`TMS_KEY_W-1:0];
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/tms_acquire.sv */
// burst pulse generator and single-slope converter
`timescale 1ns/100ps
`default_nettype none
`include "tms_consts.svh"
module tms_acquire (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  // sense comparator: high while charge above ramp
  input  wire logic                  senseAbove,
  // sequencer side
  tms_acq_if.acq                     acq
);
  typedef enum logic [1:0] {A_IDLE, A_PULSE, A_CONV} tms_acq_state_t;
  tms_acq_state_t           state_r;   // phase of acquisition
  logic [`TMS_BURST_W-1:0]  left_r;    // pulses still to send
  logic [7:0]               half_r;    // half period counter
  logic [`TMS_SIG_W-1:0]    count_r;   // ramp counter
  logic [7:0]               conv_r;    // minimum conversion time
  logic                     high_r;    // pulse level
  logic                     done_r;    // result strobe
  wire                      halfEnd  = (half_r == `TMS_PULSE_HALF - 8'h01);
  wire                      lastPulse = (left_r <= `TMS_BURST_W'(1));
  wire                      convEnd  = !senseAbove && (conv_r >= `TMS_CONV_CYCLES);
  assign acq.pulseHigh = high_r;
  assign acq.busy      = (state_r != A_IDLE);
  assign acq.done      = done_r;
  assign acq.value     = count_r;
  // pulse train then ramp count; zero pulses still converts once
  always_ff @(posedge clk_sys) begin
    done_r <= 1'b0;
    if (!resetn) begin
      state_r <= A_IDLE;
      left_r  <= '0;
      half_r  <= 8'h00;
      count_r <= '0;
      conv_r  <= 8'h00;
      high_r  <= 1'b0;
    end else begin
      case (state_r)
        A_IDLE: if (acq.start) begin
          left_r  <= acq.pulses;
          half_r  <= 8'h00;
          count_r <= '0;
          conv_r  <= 8'h00;
          state_r <= (acq.pulses == '0) ? A_CONV : A_PULSE;
        end
        A_PULSE: begin
          half_r <= halfEnd ? 8'h00 : half_r + 8'h01;
          if (halfEnd) begin
            high_r <= !high_r;
            if (high_r) begin
              left_r <= left_r - `TMS_BURST_W'(1);
              if (lastPulse) state_r <= A_CONV;
            end
          end
        end
        A_CONV: begin
          if (conv_r != 8'hff) conv_r <= conv_r + 8'h01;
          if (convEnd || count_r == '1) begin
            done_r  <= 1'b1;
            state_r <= A_IDLE;
          end else begin
            count_r <= count_r + `TMS_SIG_W'(1);
          end
        end
        default: state_r <= A_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* bench/tms_scan_props.sv */
// port assertions for the scan sequencer
`timescale 1ns/100ps
`default_nettype none
`include "tms_consts.svh"
module tms_scan_props (
  // clock and reset
  input wire logic                               clk_sys,
  input wire logic                               resetn,
  // setup
  input wire logic                               smallVariant,
  input wire logic [`TMS_NUM_KEYS*`TMS_BURST_W-1:0] pulseBurstCount,
  // drive and results
  input wire logic [`TMS_NUM_DRIVE-1:0]          driveLine,
  input wire logic [`TMS_NUM_SENSE-1:0]          senseSelect,
  input wire logic                               resultValid,
  input wire logic [`TMS_KEY_W-1:0]              resultKey,
  input wire logic [`TMS_NUM_KEYS-1:0]           keyEnabled,
  input wire logic [`TMS_KEY_W-1:0]              enabledCount,
  input wire logic                               overLimit,
  input wire logic                               scanDone
);
  logic       drv_r;    // drive seen last cycle
  logic [7:0] pulse_r;  // pulses since last result
  logic [4:0] last_r;   // key of last result
  logic       mid_r;    // a result already seen in this scan
  logic [4:0] lowKey;   // lowest enabled key
  wire        rise = |driveLine & ~drv_r;
  wire  [7:0] keyBurst = pulseBurstCount[{resultKey, 3'h0}+:8];
  // priority search, low key wins
  always_comb begin
    lowKey = 5'h00;
    for (int k = 23; k >= 0; k--) if (keyEnabled[k]) lowKey = 5'(k);
  end
  // pulse count and scan position; done wins over a same-cycle result
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      drv_r <= 1'b0;
      pulse_r <= 8'h00;
      last_r <= 5'h00;
      mid_r <= 1'b0;
    end else begin
      drv_r <= |driveLine;
      pulse_r <= resultValid ? 8'h00 : pulse_r + {7'h00, rise};
      if (resultValid) last_r <= resultKey;
      mid_r <= scanDone ? 1'b0 : (mid_r | resultValid);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_result_enabled: assert property (resultValid |-> keyEnabled[resultKey])
    else $error("result for a disabled key");
  a_first_key: assert property (resultValid && !mid_r |-> resultKey == lowKey)
    else $error("scan did not start at lowest key");
  a_key_ascend: assert property (resultValid && mid_r |-> resultKey > last_r)
    else $error("keys out of order");
  a_burst_count: assert property (resultValid |-> pulse_r == keyBurst)
    else $error("pulse count differs from key setting");
  a_drive_onehot: assert property ($onehot0(driveLine))
    else $error("more than one drive line");
  a_sense_onehot: assert property (|driveLine |-> $onehot(senseSelect))
    else $error("sense select not one-hot");
  a_quiet_result: assert property (resultValid |-> driveLine == 8'h00)
    else $error("drive pulse during result");
  a_valid_pulse: assert property (resultValid |=> !resultValid)
    else $error("result longer than one cycle");
  a_done_pulse: assert property (scanDone |=> !scanDone)
    else $error("scan done longer than one cycle");
  a_small_cap: assert property (smallVariant |-> enabledCount <= 5'h10)
    else $error("small part above its key limit");
  a_over_fallback: assert property (overLimit |-> keyEnabled[23:16] == 8'h00)
    else $error("over limit keeps upper keys");
  c_done: cover property (scanDone);
  c_over: cover property (overLimit && resultValid);
  c_top_key: cover property (resultValid && resultKey == 5'h17);
endmodule
bind tms_scan_sequencer tms_scan_props u_props (.clk_sys, .resetn, .smallVariant,
  .pulseBurstCount, .driveLine, .senseSelect, .resultValid, .resultKey, .keyEnabled,
  .enabledCount, .overLimit, .scanDone);
`default_nettype wire

/* bench/tms_matrix_model.sv */
// electrode matrix and sense comparator model
`timescale 1ns/100ps
`default_nettype none
module tms_matrix_model (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       resetn,
  // drive from the sequencer
  input wire logic [7:0] driveLine,
  // comparator out
  output logic           senseAbove
);
  logic [7:0] charge_r;  // held charge, ramps down after burst
  logic [1:0] idle_r;    // cycles without drive
  logic       drv_r;     // drive seen last cycle
  // a gap of three cycles marks the burst end; within it the low half is two
  assign senseAbove = charge_r != 8'h00;
  // each pulse adds charge, so longer bursts convert slower
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      charge_r <= 8'h00;
      idle_r <= 2'h0;
      drv_r <= 1'b0;
    end else begin
      drv_r <= |driveLine;
      if (|driveLine) idle_r <= 2'h0;
      else if (idle_r != 2'h3) idle_r <= idle_r + 2'h1;
      if (|driveLine & ~drv_r) charge_r <= (charge_r == 8'h00 ? 8'h10 : charge_r) + 8'h04;
      else if (idle_r == 2'h3 && charge_r != 8'h00) charge_r <= charge_r - 8'h01;
    end
  end
endmodule
`default_nettype wire

/* bench/tb_touch_matrix_scan_sequencer.sv */
// self-checking bench for the scan sequencer
`timescale 1ns/100ps
`default_nettype none
`include "tms_consts.svh"
module tb_touch_matrix_scan_sequencer;
  logic         clk_sys = 1'b0;       // 100 MHz
  logic         resetn = 1'b0;        // held low at start
  logic         smallVariant = 1'b0;  // part strap
  logic [191:0] lim = '0;             // integrator limits
  logic [191:0] bur = '0;             // burst counts
  wire          senseAbove;
  wire  [7:0]   driveLine;
  wire  [2:0]   senseSelect;
  wire          resultValid, overLimit, scanDone;
  wire  [4:0]   resultKey, enabledCount;
  wire  [11:0]  resultSignal;
  wire  [23:0]  keyEnabled;
  integer       seed = 65130;
  integer       n_errors = 0;
  integer       tests_run = 0;
  integer       cycles = 0;
  integer       nDone = 0;            // scan ends since last reset
  tms_scan_sequencer uut (.clk_sys, .resetn, .smallVariant,
    .normalDetectIntegratorLimit(lim), .pulseBurstCount(bur), .senseAbove,
    .driveLine, .senseSelect, .resultValid, .resultKey, .resultSignal,
    .keyEnabled, .enabledCount, .overLimit, .scanDone);
  tms_matrix_model u_model (.clk_sys, .resetn, .driveLine, .senseAbove);
  always #5 clk_sys = ~clk_sys;
  // hang guard, well above ten configs of two scans
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors = n_errors + 1;
      test_done();
    end
  end
  // sample at negedge so registered pulses are settled
  always @(negedge clk_sys) if (scanDone === 1'b1) nDone = nDone + 1;
  // enable mask a key scan should use
  function automatic logic [23:0] expMask(input logic sm, input logic [191:0] l);
    logic [23:0] m;
    for (int k = 0; k < 24; k++) m[k] = l[k*8+:8] != 8'h00;
    if (sm && $countones(m) > 16) m[23:16] = 8'h00;
    return m;
  endfunction
  // model charges 16 plus 4 per pulse, waits 3 quiet cycles, then bleeds 1 a cycle;
  // the ramp counts every conversion cycle before the comparator drops (1..59 pulses)
  function automatic logic [11:0] expSig(input logic [7:0] n);
    return 12'(20 + 4 * n);
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // bounded wait for the next result
  task automatic waitKey(output logic [4:0] key, output logic [11:0] sig);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(negedge clk_sys);
      if (resultValid === 1'b1) break;
    end
    // a result that never came counts against the run
    if (i == 3000) n_errors = n_errors + 1;
    key = resultKey;
    sig = resultSignal;
  endtask
  // load a setup under reset, then follow two full scans
  task automatic runCfg(input logic sm, input logic [191:0] l, input logic [191:0] b);
    logic [23:0] m;
    logic [4:0]  key;
    logic [11:0] sig;
    logic        over;
    @(posedge clk_sys);
    resetn <= 1'b0;
    smallVariant <= sm;
    lim <= l;
    bur <= b;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    nDone = 0;
    m = expMask(sm, l);
    over = sm && $countones(expMask(1'b0, l)) > 16;
    repeat (3) @(negedge clk_sys);
    chk(keyEnabled, m);
    // small part over its limit reports the clamped count of 16
    chk(24'(enabledCount), 24'(over ? 16 : $countones(m)));
    chk(24'(overLimit), 24'(over));
    for (int s = 0; s < 2; s++)
      for (int k = 0; k < 24; k++)
        if (m[k]) begin
          waitKey(key, sig);
          chk(24'(key), 24'(k));
          chk(24'(sig), 24'(expSig(b[k*8+:8])));
        end
    for (int i = 0; i < 200 && nDone < 2; i++) @(negedge clk_sys);
    chk(24'(nDone), 24'h000002);
  endtask
  initial begin
    logic [191:0] l, b;
    for (int k = 0; k < 24; k++) b[k*8+:8] = 8'h01 + 8'($random(seed) & 3);
    runCfg(1'b0, {24{8'h01}}, {24{8'h01}});
    runCfg(1'b1, {24{8'hff}}, {24{8'h04}});
    runCfg(1'b1, {{16{8'h07}}, {8{8'h00}}}, b);
    runCfg(1'b0, {8'h05, {23{8'h00}}}, b);
    for (int c = 0; c < 6; c++) begin
      for (int k = 0; k < 24; k++) begin
        l[k*8+:8] = ($random(seed) & 1) ? 8'($random(seed)) | 8'h01 : 8'h00;
        b[k*8+:8] = 8'h01 + 8'($random(seed) & 3);
      end
      l[(($random(seed) & 32'h7fff) % 24)*8+:8] = 8'h01;
      runCfg(1'($random(seed)), l, b);
    end
    test_done();
  end
endmodule
`default_nettype wire
